// ===== logic/cpm_pkg.sv
// shared constants and types for the control port packet engine
package cpm_pkg;
	localparam int TX_AW = 9;
	localparam int TX_DEPTH = 512;
	localparam int RX_AW = 9;
	localparam int RX_DEPTH = 512;
	localparam int HALF_AW = 10;
	localparam int LEN_W = 16;
	localparam int REM_W = 14;
	localparam int HDR_BYTES = 38;
	localparam int HDR_BITS = 304;
	localparam int FF_AW = 4;
	localparam int FF_DEPTH = 16;
	localparam logic [2:0] HDR_BEATS = 3'h5;
	localparam logic [7:0] KEEP_ALL = 8'hFF;
	localparam logic [REM_W-1:0] TX_FINAL_COUNT = 14'h0002;
	localparam logic [REM_W-1:0] TX_COUNT_STEP = 14'h0001;
	localparam logic [16:0] TX_ROUND_UP = 17'h0_0007;
	localparam logic [4:0] FF_FULL = 5'h10;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LOAD = 2'b01,
		TX_SEND = 2'b10
	} cpm_tx_state_t;
endpackage

// ===== logic/cpm_hdr_if.sv
// carrier between the receive path and the header comparator
`timescale 1ns/10ps
interface cpm_hdr_if;
	logic [63:0] beat_data;
	logic [2:0] beat_index;
	logic compare_enable;
	logic [cpm_pkg::HDR_BITS-1:0] expected;
	logic [cpm_pkg::HDR_BYTES-1:0] mask;
	logic [7:0] byte_pass;

	modport engine (output beat_data, beat_index, compare_enable, expected, mask,
		input byte_pass);
	modport comparator (input beat_data, beat_index, compare_enable, expected, mask,
		output byte_pass);
endinterface

// ===== logic/cpm_header_comparator.sv
// per-beat header comparator: eight header bytes per clock
`timescale 1ns/10ps
module cpm_header_comparator (
	cpm_hdr_if.comparator hdr // beat in, per-lane pass out
);
	always_comb begin
		int n;
		n = 0;
		hdr.byte_pass = '0;
		for (int i = 0; i < 8; i++) begin
			n = int'(hdr.beat_index) * 8 + i;
			if (hdr.compare_enable && n < cpm_pkg::HDR_BYTES) begin
				// masked-off bytes always pass
				hdr.byte_pass[i] = !hdr.mask[n] ||
					(hdr.beat_data[i*8 +: 8] == hdr.expected[n*8 +: 8]);
			end
		end
	end
endmodule // cpm_header_comparator

// ===== logic/cpm_control_port_engine.sv
// control port packet engine: transmit buffer streamer and filtered receive buffer
`timescale 1ns/10ps
// Behaviour
// - software sends only while busy reads low
// - length captured together with send request
// - request raises busy, loads counter, zeroes address
// - buffer data one clock after address
// - valid holds until ready, then back to back
// - non-final words carry full keep
// - counter two forms final contiguous keep mask
// - last marks the final word
// - after final word drop valid and busy
// - first beat enables header compare for five beats
// - write address reloads at frame start, increments
// - every received beat written into receive buffer
// - per-byte header compare under enable mask
// - all pass: strobe and latch end position
// - accepted end addresses queued with visible count
// - write address 64-bit, read port 32-bit
// - 32-bit RAM port, 64-bit stream port
module cpm_control_port_engine (
	input wire logic sys_clk, // 25 MHz system clock
	input wire logic rst_n, // async reset, active low
	output logic tx_engine_busy, // transmit in progress
	input wire logic [cpm_pkg::HALF_AW-1:0] tx_buffer_write_address, // 32-bit word address
	input wire logic [31:0] tx_buffer_write_data, // transmit buffer write data
	input wire logic tx_buffer_write_enable, // transmit buffer write strobe
	input wire logic [cpm_pkg::LEN_W-1:0] tx_frame_length, // frame length in bytes
	input wire logic tx_send_request, // start transmission
	output logic [63:0] tx_stream_data, // stream data to mac
	output logic tx_stream_valid, // stream valid
	input wire logic tx_stream_ready, // mac ready
	output logic [7:0] tx_stream_keep, // byte keep
	output logic tx_stream_last, // final word
	input wire logic [63:0] rx_stream_data, // stream data from mac
	input wire logic rx_stream_valid, // receive beat valid
	input wire logic rx_stream_last, // final receive beat
	input wire logic [cpm_pkg::HDR_BITS-1:0] header_expected_bytes, // byte n at [8n+7:8n]
	input wire logic [cpm_pkg::HDR_BYTES-1:0] header_byte_enable_mask, // bit n enables byte n
	output logic rx_frame_accepted_strobe, // one-cycle accept pulse
	output logic [cpm_pkg::RX_AW-1:0] rx_accepted_end_position, // next free 64-bit word
	output logic [4:0] end_address_fifo_count, // queued end addresses
	input wire logic end_address_fifo_pop, // pop one end address
	output logic [cpm_pkg::RX_AW-1:0] end_address_fifo_data, // popped end address
	input wire logic [cpm_pkg::HALF_AW-1:0] rx_buffer_read_address, // 32-bit word address
	output logic [31:0] rx_buffer_read_data // read data, one clock later
);
	typedef struct packed {
		cpm_pkg::cpm_tx_state_t tx_state;
		logic tx_busy;
		logic [cpm_pkg::TX_AW-1:0] tx_addr;
		logic [cpm_pkg::REM_W-1:0] tx_rem;
		logic [2:0] tx_res;
		logic tx_valid;
		logic tx_last;
		logic [7:0] tx_keep;
		logic [63:0] tx_data;
		logic rx_in_frame;
		logic [2:0] rx_beat;
		logic [cpm_pkg::RX_AW-1:0] rx_cnt;
		logic [cpm_pkg::RX_AW-1:0] rx_end_pos;
		logic [cpm_pkg::HDR_BYTES-1:0] rx_flags;
		logic rx_accept;
		logic [cpm_pkg::FF_AW-1:0] ff_wp;
		logic [cpm_pkg::FF_AW-1:0] ff_rp;
		logic [4:0] ff_cnt;
		logic [cpm_pkg::RX_AW-1:0] ff_data;
		logic [31:0] rx_rd_data;
	} cpm_state_t;

	cpm_state_t s_q;
	cpm_state_t s_d;
	logic [1:0] rst_pipe_q;
	logic rst_sync_n;
	logic [63:0] tx_mem [cpm_pkg::TX_DEPTH];
	logic [63:0] rx_mem [cpm_pkg::RX_DEPTH];
	logic [cpm_pkg::RX_AW-1:0] ff_mem [cpm_pkg::FF_DEPTH];
	logic [16:0] tx_len_sum;
	logic [cpm_pkg::REM_W-1:0] tx_rem_load;
	logic tx_take;
	logic tx_rd_en;
	logic [63:0] tx_mem_word;
	logic [7:0] tx_final_keep;
	logic rx_first;
	logic [2:0] rx_beat_now;
	logic [cpm_pkg::RX_AW-1:0] rx_buffer_write_address;
	logic [cpm_pkg::HDR_BYTES-1:0] header_match_flags;
	logic rx_pass_all;
	logic ff_push;
	logic ff_pop;

	cpm_hdr_if hdr_bus ();

	cpm_header_comparator u_header_comparator (
		.hdr(hdr_bus.comparator)
	);

	// reset is released synchronously; assertion stays asynchronous
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_pipe_q <= 2'h0;
		end else begin
			rst_pipe_q <= {rst_pipe_q[0], 1'b1};
		end
	end
	assign rst_sync_n = rst_pipe_q[1];

	assign tx_len_sum = {1'b0, tx_frame_length} + cpm_pkg::TX_ROUND_UP;
	// one extra count for the fetch ahead of the first beat
	assign tx_rem_load = tx_len_sum[16:3] + cpm_pkg::TX_COUNT_STEP;
	assign tx_take = (s_q.tx_state == cpm_pkg::TX_IDLE) && tx_send_request &&
		(tx_frame_length != 16'h0000);
	assign tx_rd_en = (s_q.tx_state == cpm_pkg::TX_LOAD) ||
		(s_q.tx_valid && tx_stream_ready && !s_q.tx_last);
	assign tx_mem_word = tx_mem[s_q.tx_addr];
	assign tx_final_keep = (s_q.tx_res == 3'h0) ? cpm_pkg::KEEP_ALL :
		(cpm_pkg::KEEP_ALL >> (4'h8 - {1'b0, s_q.tx_res}));

	assign rx_first = rx_stream_valid && !s_q.rx_in_frame;
	assign rx_beat_now = rx_first ? 3'h0 : s_q.rx_beat;
	assign rx_buffer_write_address = rx_first ? s_q.rx_end_pos : s_q.rx_cnt;
	assign hdr_bus.beat_data = rx_stream_data;
	assign hdr_bus.beat_index = rx_beat_now;
	assign hdr_bus.compare_enable = rx_stream_valid && (rx_beat_now < cpm_pkg::HDR_BEATS);
	assign hdr_bus.expected = header_expected_bytes;
	assign hdr_bus.mask = header_byte_enable_mask;

	// result flags restart at each frame's first beat
	always_comb begin
		int idx;
		idx = 0;
		header_match_flags = rx_first ? '0 : s_q.rx_flags;
		for (int i = 0; i < 8; i++) begin
			idx = int'(rx_beat_now) * 8 + i;
			if (idx < cpm_pkg::HDR_BYTES && hdr_bus.byte_pass[i]) begin
				header_match_flags[idx] = 1'b1;
			end
		end
	end
	// short frames never fill all flags and are dropped
	assign rx_pass_all = &header_match_flags;
	assign ff_push = rx_stream_valid && rx_stream_last && rx_pass_all &&
		(s_q.ff_cnt != cpm_pkg::FF_FULL);
	assign ff_pop = end_address_fifo_pop && (s_q.ff_cnt != 5'h00);

	always_comb begin
		s_d = s_q;
		s_d.rx_accept = 1'b0;
		case (s_q.tx_state)
			cpm_pkg::TX_IDLE: begin
				if (tx_take) begin
					s_d.tx_busy = 1'b1;
					s_d.tx_addr = '0;
					s_d.tx_rem = tx_rem_load;
					s_d.tx_res = tx_frame_length[2:0];
					s_d.tx_state = cpm_pkg::TX_LOAD;
				end
			end
			cpm_pkg::TX_LOAD: begin
				s_d.tx_state = cpm_pkg::TX_SEND;
			end
			cpm_pkg::TX_SEND: begin
				if (s_q.tx_valid && tx_stream_ready && s_q.tx_last) begin
					s_d.tx_valid = 1'b0;
					s_d.tx_last = 1'b0;
					s_d.tx_busy = 1'b0;
					s_d.tx_state = cpm_pkg::TX_IDLE;
				end
			end
			default: begin
				s_d.tx_state = cpm_pkg::TX_IDLE;
			end
		endcase
		if (tx_rd_en) begin
			s_d.tx_data = tx_mem_word;
			s_d.tx_addr = s_q.tx_addr + 9'h001;
			s_d.tx_rem = s_q.tx_rem - cpm_pkg::TX_COUNT_STEP;
			s_d.tx_valid = 1'b1;
			s_d.tx_last = (s_q.tx_rem == cpm_pkg::TX_FINAL_COUNT);
			s_d.tx_keep = (s_q.tx_rem == cpm_pkg::TX_FINAL_COUNT) ?
				tx_final_keep : cpm_pkg::KEEP_ALL;
		end

		if (rx_stream_valid) begin
			s_d.rx_in_frame = !rx_stream_last;
			s_d.rx_cnt = rx_buffer_write_address + 9'h001;
			s_d.rx_beat = (rx_beat_now < cpm_pkg::HDR_BEATS) ? rx_beat_now + 3'h1 :
				rx_beat_now;
			s_d.rx_flags = header_match_flags;
			if (rx_stream_last && rx_pass_all) begin
				s_d.rx_accept = 1'b1;
				s_d.rx_end_pos = rx_buffer_write_address + 9'h001;
			end
		end

		// a full queue drops the end address; the frame stays in the buffer
		if (ff_push) begin
			s_d.ff_wp = s_q.ff_wp + 4'h1;
		end
		if (ff_pop) begin
			s_d.ff_data = ff_mem[s_q.ff_rp];
			s_d.ff_rp = s_q.ff_rp + 4'h1;
		end
		case ({ff_push, ff_pop})
			2'b10: s_d.ff_cnt = s_q.ff_cnt + 5'h01;
			2'b01: s_d.ff_cnt = s_q.ff_cnt - 5'h01;
			default: s_d.ff_cnt = s_q.ff_cnt;
		endcase

		s_d.rx_rd_data = rx_buffer_read_address[0] ?
			rx_mem[rx_buffer_read_address[9:1]][63:32] :
			rx_mem[rx_buffer_read_address[9:1]][31:0];
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// even 32-bit word is the low half, so it leaves first on the stream
	always_ff @(posedge sys_clk) begin
		if (tx_buffer_write_enable) begin
			if (tx_buffer_write_address[0]) begin
				tx_mem[tx_buffer_write_address[9:1]][63:32] <= tx_buffer_write_data;
			end else begin
				tx_mem[tx_buffer_write_address[9:1]][31:0] <= tx_buffer_write_data;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rx_stream_valid) begin
			rx_mem[rx_buffer_write_address] <= rx_stream_data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ff_push) begin
			ff_mem[s_q.ff_wp] <= s_d.rx_end_pos;
		end
	end

	assign tx_engine_busy = s_q.tx_busy;
	assign tx_stream_data = s_q.tx_data;
	assign tx_stream_valid = s_q.tx_valid;
	assign tx_stream_keep = s_q.tx_keep;
	assign tx_stream_last = s_q.tx_last;
	assign rx_frame_accepted_strobe = s_q.rx_accept;
	assign rx_accepted_end_position = s_q.rx_end_pos;
	assign end_address_fifo_count = s_q.ff_cnt;
	assign end_address_fifo_data = s_q.ff_data;
	assign rx_buffer_read_data = s_q.rx_rd_data;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_sync_n);

	sequence s_tx_take;
		tx_take;
	endsequence
	sequence s_tx_final_beat;
		tx_stream_valid && tx_stream_ready && tx_stream_last;
	endsequence
	sequence s_rx_continue;
		rx_stream_valid && !rx_stream_last ##1 rx_stream_valid;
	endsequence

	property p_tx_take_busy;
		s_tx_take |=> tx_engine_busy && s_q.tx_addr == 9'h000 &&
			s_q.tx_state == cpm_pkg::TX_LOAD;
	endproperty
	a_tx_take_busy: assert property (p_tx_take_busy) else $error("request not taken");

	property p_tx_len_capture;
		s_tx_take |=> s_q.tx_rem == $past(tx_rem_load);
	endproperty
	a_tx_len_capture: assert property (p_tx_len_capture) else $error("length not captured");

	property p_tx_first_word;
		s_tx_take ##1 1'b1 |=> tx_stream_valid && tx_stream_data == $past(tx_mem_word);
	endproperty
	a_tx_first_word: assert property (p_tx_first_word) else $error("first word wrong");

	property p_tx_hold;
		tx_stream_valid && !tx_stream_ready |=> tx_stream_valid &&
			$stable(tx_stream_data) && $stable(tx_stream_last);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("word dropped before ready");

	property p_tx_keep_full;
		tx_stream_valid && !tx_stream_last |-> tx_stream_keep == cpm_pkg::KEEP_ALL;
	endproperty
	a_tx_keep_full: assert property (p_tx_keep_full) else $error("keep not full");

	property p_tx_keep_final;
		tx_stream_valid && tx_stream_last |-> tx_stream_keep[0] &&
			((tx_stream_keep & (tx_stream_keep + 8'h01)) == 8'h00) &&
			tx_stream_keep == tx_final_keep;
	endproperty
	a_tx_keep_final: assert property (p_tx_keep_final) else $error("final keep bad");

	property p_tx_last_count;
		tx_stream_last |-> s_q.tx_rem == cpm_pkg::TX_COUNT_STEP;
	endproperty
	a_tx_last_count: assert property (p_tx_last_count) else $error("last at wrong word");

	property p_tx_done;
		s_tx_final_beat |=> !tx_stream_valid && !tx_engine_busy;
	endproperty
	a_tx_done: assert property (p_tx_done) else $error("no return to idle");

	property p_rx_enable;
		rx_first |-> hdr_bus.compare_enable && hdr_bus.beat_index == 3'h0 &&
			rx_buffer_write_address == s_q.rx_end_pos;
	endproperty
	a_rx_enable: assert property (p_rx_enable) else $error("frame start mishandled");

	property p_rx_increment;
		s_rx_continue |-> rx_buffer_write_address == $past(rx_buffer_write_address) + 9'h001;
	endproperty
	a_rx_increment: assert property (p_rx_increment) else $error("address not stepped");

	property p_rx_accept;
		rx_stream_valid && rx_stream_last && rx_pass_all |=> rx_frame_accepted_strobe &&
			s_q.rx_end_pos == $past(rx_buffer_write_address) + 9'h001;
	endproperty
	a_rx_accept: assert property (p_rx_accept) else $error("accept not latched");

	property p_rx_reject;
		rx_stream_valid && rx_stream_last && !rx_pass_all |=> !rx_frame_accepted_strobe &&
			$stable(s_q.rx_end_pos);
	endproperty
	a_rx_reject: assert property (p_rx_reject) else $error("rejected frame kept");

	property p_ff_count;
		ff_push && !end_address_fifo_pop |=>
			end_address_fifo_count == $past(end_address_fifo_count) + 5'h01;
	endproperty
	a_ff_count: assert property (p_ff_count) else $error("queue count wrong");
endmodule // cpm_control_port_engine

// ===== verif/cpm_mac_model.sv
// far-side mac model: transmit ready source and receive beat source
`timescale 1ns/10ps
module cpm_mac_model (
	input wire logic sys_clk, // clock
	input wire logic slow, // stall ready at random
	output logic tx_stream_ready, // ready toward engine
	output logic [63:0] rx_stream_data, // receive beat
	output logic rx_stream_valid, // receive valid
	output logic rx_stream_last // receive final beat
);
	initial begin
		tx_stream_ready = 1'b0;
		rx_stream_data = 64'h0000_0000_0000_0000;
		rx_stream_valid = 1'b0;
		rx_stream_last = 1'b0;
	end
	always @(posedge sys_clk) begin
		#1 tx_stream_ready <= slow ? 1'($urandom % 2) : 1'b1;
	end
	task automatic send_beat(input logic [63:0] d, input logic l);
		@(posedge sys_clk);
		#1;
		rx_stream_data = d;
		rx_stream_valid = 1'b1;
		rx_stream_last = l;
	endtask
	task automatic idle();
		@(posedge sys_clk);
		#1;
		// no stale beat left on the data lines
		rx_stream_data = ~rx_stream_data;
		rx_stream_valid = 1'b0;
		rx_stream_last = 1'b0;
	endtask
endmodule // cpm_mac_model

// ===== verif/control_port_packet_mac_test.sv
// self-checking bench for the control port packet engine
`timescale 1ns/10ps
module control_port_packet_mac_test;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic slow = 1'b0;
	logic busy, tx_valid, tx_ready, tx_last, rx_valid, rx_last, acc;
	logic tx_we = 1'b0;
	logic tx_req = 1'b0;
	logic pop = 1'b0;
	logic [cpm_pkg::HALF_AW-1:0] tx_wa = '0;
	logic [cpm_pkg::HALF_AW-1:0] rx_ra = '0;
	logic [31:0] tx_wd = '0;
	logic [31:0] rx_rd;
	logic [cpm_pkg::LEN_W-1:0] tx_len = '0;
	logic [63:0] tx_data, rx_data;
	logic [7:0] tx_keep;
	logic [cpm_pkg::HDR_BITS-1:0] hdr = '0;
	logic [cpm_pkg::HDR_BYTES-1:0] mask = '0;
	logic [cpm_pkg::RX_AW-1:0] end_pos, ff_data;
	logic [4:0] ff_cnt;
	logic [72:0] tx_q[$];
	logic [72:0] acc_q[$];
	logic [63:0] beats[6];
	int e = 0;
	int err_total = 0;
	int compares = 0;

	always #20 sys_clk = ~sys_clk;

	cpm_mac_model mac (.sys_clk(sys_clk), .slow(slow), .tx_stream_ready(tx_ready),
		.rx_stream_data(rx_data), .rx_stream_valid(rx_valid), .rx_stream_last(rx_last));

	cpm_control_port_engine dut (.sys_clk(sys_clk), .rst_n(rst_n), .tx_engine_busy(busy),
		.tx_buffer_write_address(tx_wa), .tx_buffer_write_data(tx_wd),
		.tx_buffer_write_enable(tx_we), .tx_frame_length(tx_len), .tx_send_request(tx_req),
		.tx_stream_data(tx_data), .tx_stream_valid(tx_valid), .tx_stream_ready(tx_ready),
		.tx_stream_keep(tx_keep), .tx_stream_last(tx_last), .rx_stream_data(rx_data),
		.rx_stream_valid(rx_valid), .rx_stream_last(rx_last),
		.header_expected_bytes(hdr), .header_byte_enable_mask(mask),
		.rx_frame_accepted_strobe(acc), .rx_accepted_end_position(end_pos),
		.end_address_fifo_count(ff_cnt), .end_address_fifo_pop(pop),
		.end_address_fifo_data(ff_data), .rx_buffer_read_address(rx_ra),
		.rx_buffer_read_data(rx_rd));

	task automatic tick();
		@(posedge sys_clk);
		#1;
	endtask

	task automatic chk(input logic [72:0] got, input logic [72:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic wait_idle();
		int to;
		to = 0;
		while (busy !== 1'b0) begin
			tick();
			to++;
			if (to > 600) begin
				chk(1, 0, "busy never cleared");
				print_verdict();
			end
		end
	endtask

	// monitor: each handshaken beat and each accept pulse takes the oldest note
	always @(negedge sys_clk) begin
		if (rst_n && (tx_valid === 1'b1) && (tx_ready === 1'b1)) begin
			if (tx_q.size() == 0) chk(1, 0, "extra transmit beat");
			else chk({tx_last, tx_keep, tx_data}, tx_q.pop_front(), "tx beat");
		end
		if (acc === 1'b1) begin
			if (acc_q.size() == 0) chk(1, 0, "unwanted accept");
			else chk(end_pos, acc_q.pop_front(), "end position");
		end
	end

	task automatic send(input int len);
		logic [31:0] w[$];
		int n, r;
		wait_idle();
		n = (len + 7) / 8;
		r = ((len - 1) % 8) + 1;
		for (int i = 0; i < 2 * n; i++) begin
			w.push_back($urandom);
			tx_we = 1'b1;
			tx_wa = i[9:0];
			tx_wd = w[i];
			tick();
		end
		tx_we = 1'b0;
		for (int k = 0; k < n; k++) begin
			tx_q.push_back({k == n - 1, k == n - 1 ? 8'hFF >> (8 - r) : 8'hFF,
				w[2 * k + 1], w[2 * k]});
		end
		tx_len = len[15:0];
		tx_req = 1'b1;
		tick();
		chk(busy, 1, "busy after request");
		// held one more edge while busy: must be ignored
		tx_len = 16'h0003;
		tick();
		tx_req = 1'b0;
		wait_idle();
		chk({tx_valid, 8'(tx_q.size())}, 0, "end of frame");
	endtask

	task automatic frame(input int flip, input logic ok);
		logic [383:0] h;
		h = {80'h0, hdr};
		if (flip >= 0) h[flip * 8 +: 8] = ~h[flip * 8 +: 8];
		for (int k = 0; k < 6; k++) begin
			beats[k] = k < 5 ? h[k * 64 +: 64] : {$urandom, $urandom};
			mac.send_beat(beats[k], k == 5);
		end
		if (ok) begin
			e += 6;
			acc_q.push_back(73'(e));
		end
	endtask

	initial begin
		void'($urandom(67087));
		repeat (8) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		repeat (4) tick();
		chk({busy, tx_valid, ff_cnt, end_pos}, 0, "reset state");
		tx_len = '0;
		tx_req = 1'b1;
		tick();
		tx_req = 1'b0;
		tick();
		chk(busy, 0, "zero length request");
		for (int len = 1; len <= 9; len++) send(len);
		slow = 1'b1;
		repeat (4) send(1 + $urandom % 64);
		slow = 1'b0;
		for (int i = 0; i < 38; i++) hdr[i * 8 +: 8] = 8'($urandom);
		mask = 38'({$urandom, $urandom});
		mask[0] = 1'b1;
		mask[37] = 1'b0;
		frame(37, 1'b1);
		frame(0, 1'b0);
		frame(-1, 1'b1);
		mac.idle();
		repeat (3) tick();
		chk(ff_cnt, 2, "queued count");
		pop = 1'b1;
		tick();
		chk(ff_data, 6, "first end address");
		tick();
		pop = 1'b0;
		chk(ff_data, 12, "second end address");
		pop = 1'b1;
		tick();
		pop = 1'b0;
		tick();
		chk({ff_cnt, ff_data}, 12, "pop when empty");
		for (int i = 12; i < 24; i++) begin
			rx_ra = i[9:0];
			tick();
			chk(rx_rd, beats[(i - 12) / 2][32 * (i % 2) +: 32], "stored word");
		end
		// control-port filter: ipv4, tcp, client and local address, port 21
		mask = '0;
		hdr[12 * 8 +: 16] = 16'h0008;
		hdr[14 * 8 +: 8] = 8'h45;
		hdr[23 * 8 +: 8] = 8'h06;
		hdr[36 * 8 +: 16] = 16'h1500;
		mask[14:12] = 3'h7;
		mask[23] = 1'b1;
		mask[33:26] = 8'hFF;
		mask[37:36] = 2'h3;
		frame(-1, 1'b1);
		frame(37, 1'b0);
		mac.idle();
		repeat (3) tick();
		chk(ff_cnt, 1, "filtered frame queued");
		pop = 1'b1;
		tick();
		pop = 1'b0;
		chk(ff_data, 18, "filtered end address");
		chk(73'(acc_q.size()), 0, "accept missing");
		print_verdict();
	end
endmodule // control_port_packet_mac_test
